// >>> pkg/eor_pkg.sv
// Shared constants of the nonvolatile store and option ROM access unit.
package eor_pkg;
  localparam logic [7:0]  CFG_ROM_BASE   = 8'h30;
  localparam logic [7:0]  REG_NV_CTRL    = 8'h84;
  localparam logic [7:0]  REG_NV_DATA    = 8'h88;
  localparam int          NV_RD_BIT      = 8;
  localparam int          NV_WR_BIT      = 9;
  localparam int          NV_BUSY_BIT    = 10;
  localparam int          NV_PRES_BIT    = 12;
  localparam int          NV_CKERR_BIT   = 13;
  localparam int          NV_FLPRES_BIT  = 14;
  localparam int          NV_FWEN_BIT    = 15;
  localparam int          ROM_EN_BIT     = 0;
  localparam logic [31:0] ROM_BASE_RST   = 32'h0000_0000;
  localparam int          NV_DWORDS_DEF  = 32;
  localparam int          ROM_AW_DEF     = 12;
  localparam logic [1:0]  NV_OP_RD       = 2'h2;
  localparam logic [1:0]  NV_OP_WR       = 2'h1;
  localparam logic [1:0]  NV_OP_EWEN     = 2'h0;
  localparam logic [5:0]  NV_EWEN_ADDR   = 6'h30;
  localparam int          CLK_MHZ        = 250;
  localparam int          SK_HALF_NS     = 500;
  localparam int          SK_HALF_CYC    = (SK_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int          WR_TIMEOUT_US  = 10000;
  localparam int          WR_TIMEOUT_CYC = WR_TIMEOUT_US * CLK_MHZ;
  localparam int          ROM_ACC_NS     = 150;
  localparam int          ROM_ACC_CYC    = (ROM_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int          ROM_WE_NS      = 100;
  localparam int          ROM_WE_CYC     = (ROM_WE_NS * CLK_MHZ + 999) / 1000;
endpackage : eor_pkg

// >>> pkg/eor_nv_if.sv
// Word request and answer carrier between sequencer and serial engine.
`timescale 1ns/1ps
interface eor_nv_if;
  logic        req;
  logic        ack;
  logic [1:0]  op;
  logic [5:0]  addr;
  logic [15:0] wdata;
  logic        done;
  logic        ok;
  logic [15:0] rdata;
  modport master (output req, op, addr, wdata, input ack, done, ok, rdata);
  modport engine (input req, op, addr, wdata, output ack, done, ok, rdata);
endinterface : eor_nv_if

// >>> design/eor_nv_serial.sv
// Three-wire serial engine moving one 16-bit word to or from the EEPROM.
`timescale 1ns/1ps
module eor_nv_serial
  import eor_pkg::*;
#(
  parameter int unsigned WAIT_CYC = WR_TIMEOUT_CYC
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  eor_nv_if.engine  nv,
  output logic      nvCs,
  output logic      nvSk,
  output logic      nvDi,
  input  wire logic nvDo
);
  import eor_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_SHIFT, S_GAP, S_POLL, S_DONE} eor_ser_t;

  if (WAIT_CYC < 1) begin : g_chk
    $error("WAIT_CYC must be at least one");
  end

  eor_ser_t    st_r, st_nxt;
  logic [7:0]  div_r, div_nxt;
  logic [4:0]  bit_r, bit_nxt;
  logic [24:0] sh_r, sh_nxt;
  logic [16:0] in_r, in_nxt;
  logic [31:0] wait_r, wait_nxt;
  logic        isRd_r, isRd_nxt, isWr_r, isWr_nxt, ok_r, ok_nxt;
  logic        cs_r, cs_nxt, sk_r, sk_nxt, di_r;
  logic        doM_r, doS_r, divEnd;

  assign divEnd   = div_r == 8'(SK_HALF_CYC - 1);
  assign nv.ack   = st_r == S_IDLE;
  assign nv.done  = st_r == S_DONE && divEnd;
  assign nv.ok    = ok_r;
  assign nv.rdata = in_r[15:0];
  assign nvCs     = cs_r;
  assign nvSk     = sk_r;
  assign nvDi     = di_r;

  always_comb begin
    st_nxt   = st_r;
    div_nxt  = divEnd ? 8'h00 : div_r + 8'h01;
    bit_nxt  = bit_r;
    sh_nxt   = sh_r;
    in_nxt   = in_r;
    wait_nxt = wait_r;
    isRd_nxt = isRd_r;
    isWr_nxt = isWr_r;
    ok_nxt   = ok_r;
    cs_nxt   = cs_r;
    sk_nxt   = sk_r;
    case (st_r)
      S_IDLE: begin
        div_nxt = 8'h00;
        if (nv.req) begin
          sh_nxt   = {1'b1, nv.op, nv.addr, nv.wdata};
          isRd_nxt = nv.op == NV_OP_RD;
          isWr_nxt = nv.op == NV_OP_WR;
          bit_nxt  = nv.op == NV_OP_RD ? 5'd26 : (nv.op == NV_OP_WR ? 5'd25 : 5'd9);
          ok_nxt   = 1'b1;
          cs_nxt   = 1'b1;
          st_nxt   = S_SHIFT;
        end
      end
      S_SHIFT: begin
        if (divEnd) begin
          sk_nxt = ~sk_r;
          if (sk_r) begin
            in_nxt  = {in_r[15:0], doS_r};
            sh_nxt  = {sh_r[23:0], 1'b0};
            bit_nxt = bit_r - 5'd1;
            if (bit_r == 5'd1) begin
              // A missing part leaves the line pulled high where the zero lead bit belongs.
              if (isRd_r) ok_nxt = ~in_nxt[16];
              cs_nxt = 1'b0;
              st_nxt = isWr_r ? S_GAP : S_DONE;
            end
          end
        end
      end
      S_GAP: begin
        if (divEnd) begin
          cs_nxt   = 1'b1;
          wait_nxt = 32'h0;
          st_nxt   = S_POLL;
        end
      end
      S_POLL: begin
        wait_nxt = wait_r + 32'h1;
        // The first poll cycles still see the pull-up through the synchroniser.
        if ((doS_r && wait_r > 32'h1) || wait_r == WAIT_CYC - 1) begin
          ok_nxt = doS_r;
          cs_nxt = 1'b0;
          st_nxt = S_DONE;
        end
      end
      S_DONE: begin
        if (divEnd) st_nxt = S_IDLE;
      end
      default: st_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r   <= S_IDLE;
      div_r  <= 8'h00;
      bit_r  <= 5'h00;
      sh_r   <= 25'h0;
      in_r   <= 17'h0;
      wait_r <= 32'h0;
      isRd_r <= 1'b0;
      isWr_r <= 1'b0;
      ok_r   <= 1'b0;
      cs_r   <= 1'b0;
      sk_r   <= 1'b0;
      di_r   <= 1'b0;
      doM_r  <= 1'b0;
      doS_r  <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      div_r  <= div_nxt;
      bit_r  <= bit_nxt;
      sh_r   <= sh_nxt;
      in_r   <= in_nxt;
      wait_r <= wait_nxt;
      isRd_r <= isRd_nxt;
      isWr_r <= isWr_nxt;
      ok_r   <= ok_nxt;
      cs_r   <= cs_nxt;
      sk_r   <= sk_nxt;
      di_r   <= sh_nxt[24];
      doM_r  <= nvDo;
      doS_r  <= doM_r;
    end
  end
endmodule : eor_nv_serial

// >>> design/eor_top.sv
// EEPROM reload and access sequencer with option ROM window and flash byte writes.
`timescale 1ns/1ps
module eor_top
  import eor_pkg::*;
#(
  parameter int unsigned WR_WAIT_CYC = WR_TIMEOUT_CYC,
  parameter int          NV_DWORDS   = NV_DWORDS_DEF,
  parameter int          ROM_AW      = ROM_AW_DEF
) (
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  input  wire logic                       regWrEn,
  input  wire logic                       regRdEn,
  input  wire logic [7:0]                 regAddr,
  input  wire logic [31:0]                regWrData,
  output logic      [31:0]                regRdData,
  input  wire logic                       romReq,
  input  wire logic                       romWr,
  input  wire logic [31:0]                romAddr,
  input  wire logic [3:0]                 romBe,
  input  wire logic [31:0]                romWrData,
  output logic                            romHit,
  output logic                            romAck,
  output logic      [31:0]                romRdData,
  output logic      [ROM_AW-1:0]          romPinAddr,
  input  wire logic [7:0]                 romPinDqIn,
  output logic      [7:0]                 romPinDqOut,
  output logic                            romPinDqOe,
  output logic                            romPinCe_n,
  output logic                            romPinOe_n,
  output logic                            romPinWe_n,
  input  wire logic                       romStrapPresent,
  input  wire logic                       flashStrapPresent,
  output logic                            nvCs,
  output logic                            nvSk,
  output logic                            nvDi,
  input  wire logic                       nvDo,
  output logic                            cfgLoadValid,
  output logic      [$clog2(NV_DWORDS)-1:0] cfgLoadIndex,
  output logic      [31:0]                cfgLoadData,
  output logic                            cfgLoadDone,
  output logic                            nvStorePresent,
  output logic                            nvChecksumError
);
  import eor_pkg::*;

  localparam int IDX_W = $clog2(NV_DWORDS);
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(NV_DWORDS - 1);

  if (NV_DWORDS < 2 || NV_DWORDS > 32 || (1 << IDX_W) != NV_DWORDS) begin : g_chkNv
    $error("NV_DWORDS must be a power of two from 2 to 32");
  end
  if (ROM_AW < 11 || ROM_AW > 20) begin : g_chkRom
    $error("ROM_AW must lie between 11 and 20");
  end

  typedef enum logic [2:0] {T_IDLE, T_RD_HI, T_RD_LO, T_EWEN, T_WR_HI, T_WR_LO} eor_seq_t;
  typedef enum logic [2:0] {R_IDLE, R_RD, R_WE, R_ACK} eor_rom_t;

  eor_nv_if nvBus ();

  eor_nv_serial #(.WAIT_CYC(WR_WAIT_CYC)) u_serial (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .nv      (nvBus),
    .nvCs    (nvCs),
    .nvSk    (nvSk),
    .nvDi    (nvDi),
    .nvDo    (nvDo)
  );

  eor_seq_t         st_r, st_nxt;
  logic             boot_r, boot_nxt, sent_r, sent_nxt;
  logic [IDX_W-1:0] idx_r, idx_nxt;
  logic [15:0]      hiWord_r, hiWord_nxt;
  logic [31:0]      data_r, data_nxt, sum_r, sum_nxt, load_r, load_nxt, dword;
  logic             busy_r, busy_nxt, rdCmd_r, rdCmd_nxt, wrCmd_r, wrCmd_nxt;
  logic             pres_r, pres_nxt, ckErr_r, ckErr_nxt, fwen_r, fwen_nxt;
  logic             loadV_r, loadV_nxt, loadD_r, loadD_nxt;
  logic [31:0]      base_r, base_nxt, baseMask, ctrlRd, rd_r, rd_nxt;
  logic [1:0]       strapM_r, strapS_r, capCnt_r;
  logic             romPres_r, flashPres_r, wrOk, ctrlWr;

  assign dword           = {hiWord_r, nvBus.rdata};
  assign ctrlWr          = regWrEn && regAddr == REG_NV_CTRL;
  // Holding off one cycle after a load lets the index step before the next word is asked for.
  assign nvBus.req       = !sent_r && st_r != T_IDLE && !loadV_r;
  assign nvBus.op        = st_r == T_EWEN ? NV_OP_EWEN : ((st_r == T_WR_HI || st_r == T_WR_LO) ? NV_OP_WR : NV_OP_RD);
  assign nvBus.addr      = st_r == T_EWEN ? NV_EWEN_ADDR : 6'({idx_r, st_r == T_RD_LO || st_r == T_WR_LO});
  assign nvBus.wdata     = st_r == T_WR_HI ? data_r[31:16] : data_r[15:0];
  assign cfgLoadValid    = loadV_r;
  assign cfgLoadIndex    = idx_r;
  assign cfgLoadData     = load_r;
  assign cfgLoadDone     = loadD_r;
  assign nvStorePresent  = pres_r;
  assign nvChecksumError = ckErr_r;
  assign regRdData       = rd_r;

  always_comb begin
    ctrlRd                = 32'h0;
    ctrlRd[IDX_W-1:0]     = idx_r;
    ctrlRd[NV_RD_BIT]     = rdCmd_r;
    ctrlRd[NV_WR_BIT]     = wrCmd_r;
    ctrlRd[NV_BUSY_BIT]   = busy_r;
    ctrlRd[NV_PRES_BIT]   = pres_r;
    ctrlRd[NV_CKERR_BIT]  = ckErr_r;
    ctrlRd[NV_FLPRES_BIT] = flashPres_r;
    ctrlRd[NV_FWEN_BIT]   = fwen_r;
  end

  always_comb begin
    st_nxt     = st_r;
    boot_nxt   = boot_r;
    sent_nxt   = sent_r;
    idx_nxt    = idx_r;
    hiWord_nxt = hiWord_r;
    data_nxt   = data_r;
    sum_nxt    = sum_r;
    load_nxt   = load_r;
    busy_nxt   = busy_r;
    rdCmd_nxt  = rdCmd_r;
    wrCmd_nxt  = wrCmd_r;
    pres_nxt   = pres_r;
    ckErr_nxt  = ckErr_r;
    fwen_nxt   = fwen_r;
    loadV_nxt  = 1'b0;
    loadD_nxt  = 1'b0;
    if (nvBus.req && nvBus.ack) sent_nxt = 1'b1;
    if (nvBus.done) begin
      sent_nxt = 1'b0;
      case (st_r)
        T_RD_HI: begin
          if (boot_r && idx_r == '0 && !nvBus.ok) begin
            pres_nxt  = 1'b0;
            boot_nxt  = 1'b0;
            busy_nxt  = 1'b0;
            loadD_nxt = 1'b1;
            st_nxt    = T_IDLE;
          end else begin
            hiWord_nxt = nvBus.rdata;
            st_nxt     = T_RD_LO;
          end
        end
        T_RD_LO: begin
          if (boot_r) begin
            pres_nxt = 1'b1;
            if (idx_r == LAST_IDX) begin
              ckErr_nxt = sum_r != dword;
              boot_nxt  = 1'b0;
              busy_nxt  = 1'b0;
              loadD_nxt = 1'b1;
              st_nxt    = T_IDLE;
            end else begin
              load_nxt  = dword;
              loadV_nxt = 1'b1;
              sum_nxt   = sum_r + dword;
              st_nxt    = T_RD_HI;
            end
          end else begin
            data_nxt  = dword;
            busy_nxt  = 1'b0;
            rdCmd_nxt = 1'b0;
            st_nxt    = T_IDLE;
          end
        end
        T_EWEN:  st_nxt = T_WR_HI;
        T_WR_HI: st_nxt = T_WR_LO;
        T_WR_LO: begin
          busy_nxt  = 1'b0;
          wrCmd_nxt = 1'b0;
          st_nxt    = T_IDLE;
        end
        default: st_nxt = T_IDLE;
      endcase
    end
    if (loadV_r) idx_nxt = idx_r + 1'b1;
    if (ctrlWr) begin
      fwen_nxt = regWrData[NV_FWEN_BIT];
      if (!busy_r && st_r == T_IDLE) begin
        idx_nxt = regWrData[IDX_W-1:0];
        if (pres_r && regWrData[NV_BUSY_BIT] && (regWrData[NV_RD_BIT] ^ regWrData[NV_WR_BIT])) begin
          busy_nxt  = 1'b1;
          rdCmd_nxt = regWrData[NV_RD_BIT];
          wrCmd_nxt = regWrData[NV_WR_BIT];
          st_nxt    = regWrData[NV_RD_BIT] ? T_RD_HI : T_EWEN;
        end
      end
    end
    if (regWrEn && regAddr == REG_NV_DATA && !busy_r) data_nxt = regWrData;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r     <= T_RD_HI;
      boot_r   <= 1'b1;
      sent_r   <= 1'b0;
      idx_r    <= '0;
      hiWord_r <= 16'h0000;
      data_r   <= 32'h0000_0000;
      sum_r    <= 32'h0000_0000;
      load_r   <= 32'h0000_0000;
      busy_r   <= 1'b1;
      rdCmd_r  <= 1'b0;
      wrCmd_r  <= 1'b0;
      pres_r   <= 1'b0;
      ckErr_r  <= 1'b0;
      fwen_r   <= 1'b0;
      loadV_r  <= 1'b0;
      loadD_r  <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      boot_r   <= boot_nxt;
      sent_r   <= sent_nxt;
      idx_r    <= idx_nxt;
      hiWord_r <= hiWord_nxt;
      data_r   <= data_nxt;
      sum_r    <= sum_nxt;
      load_r   <= load_nxt;
      busy_r   <= busy_nxt;
      rdCmd_r  <= rdCmd_nxt;
      wrCmd_r  <= wrCmd_nxt;
      pres_r   <= pres_nxt;
      ckErr_r  <= ckErr_nxt;
      fwen_r   <= fwen_nxt;
      loadV_r  <= loadV_nxt;
      loadD_r  <= loadD_nxt;
    end
  end

  // Base register: only bits above the ROM size and enable bit 0 are writable, all zero when no ROM.
  assign baseMask = romPres_r ? ((32'hFFFF_FFFF << ROM_AW) | 32'h0000_0001) : 32'h0000_0000;
  assign wrOk     = flashPres_r && fwen_r;
  assign romHit   = romReq && base_r[ROM_EN_BIT] && romAddr[31:ROM_AW] == base_r[31:ROM_AW];

  always_comb begin
    base_nxt = base_r;
    if (regWrEn && regAddr == CFG_ROM_BASE) base_nxt = regWrData & baseMask;
    rd_nxt = rd_r;
    if (regRdEn) begin
      case (regAddr)
        CFG_ROM_BASE: rd_nxt = base_r;
        REG_NV_CTRL:  rd_nxt = ctrlRd;
        REG_NV_DATA:  rd_nxt = data_r;
        default:      rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Straps are pins: two flops, then caught once the reset has been released.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      base_r      <= ROM_BASE_RST;
      rd_r        <= 32'h0000_0000;
      strapM_r    <= 2'h0;
      strapS_r    <= 2'h0;
      capCnt_r    <= 2'h0;
      romPres_r   <= 1'b0;
      flashPres_r <= 1'b0;
    end else begin
      base_r   <= base_nxt;
      rd_r     <= rd_nxt;
      strapM_r <= {flashStrapPresent, romStrapPresent};
      strapS_r <= strapM_r;
      if (capCnt_r != 2'h3) capCnt_r <= capCnt_r + 2'h1;
      if (capCnt_r == 2'h2) begin
        romPres_r   <= strapS_r[0];
        flashPres_r <= strapS_r[0] & strapS_r[1];
      end
    end
  end

  eor_rom_t    rs_r, rs_nxt;
  logic [1:0]  lane_r, lane_nxt;
  logic [3:0]  be_r, be_nxt;
  logic [7:0]  cnt_r, cnt_nxt, dqM_r, dqS_r, dqOut_r, dqOut_nxt;
  logic [31:0] romRd_r, romRd_nxt;
  logic [ROM_AW-1:0] a_r, a_nxt;
  logic        ce_r, ce_nxt, oe_r, oe_nxt, we_r, we_nxt, dqOe_r, dqOe_nxt;

  assign romAck      = rs_r == R_ACK;
  assign romRdData   = romRd_r;
  assign romPinAddr  = a_r;
  assign romPinDqOut = dqOut_r;
  assign romPinDqOe  = dqOe_r;
  assign romPinCe_n  = ce_r;
  assign romPinOe_n  = oe_r;
  assign romPinWe_n  = we_r;

  always_comb begin
    rs_nxt    = rs_r;
    lane_nxt  = lane_r;
    be_nxt    = be_r;
    cnt_nxt   = cnt_r + 8'h01;
    romRd_nxt = romRd_r;
    a_nxt     = a_r;
    dqOut_nxt = dqOut_r;
    ce_nxt    = ce_r;
    oe_nxt    = oe_r;
    we_nxt    = we_r;
    dqOe_nxt  = dqOe_r;
    case (rs_r)
      R_IDLE: begin
        if (romHit) begin
          be_nxt   = romBe;
          a_nxt    = {romAddr[ROM_AW-1:2], 2'b00};
          lane_nxt = 2'h0;
          cnt_nxt  = 8'h00;
          if (!romWr) begin
            romRd_nxt = 32'h0000_0000;
            rs_nxt    = R_RD;
          end else if (wrOk && $onehot(romBe)) begin
            lane_nxt  = {romBe[3] | romBe[2], romBe[3] | romBe[1]};
            a_nxt     = {romAddr[ROM_AW-1:2], romBe[3] | romBe[2], romBe[3] | romBe[1]};
            dqOut_nxt = romWrData[8 * lane_nxt +: 8];
            dqOe_nxt  = 1'b1;
            ce_nxt    = 1'b0;
            we_nxt    = 1'b0;
            rs_nxt    = R_WE;
          end else begin
            rs_nxt = R_ACK;
          end
        end
      end
      R_RD: begin
        a_nxt = {a_r[ROM_AW-1:2], lane_r};
        if (be_r[lane_r] && cnt_r != 8'(ROM_ACC_CYC + 2)) begin
          ce_nxt = 1'b0;
          oe_nxt = 1'b0;
        end else begin
          if (be_r[lane_r]) romRd_nxt[8 * lane_r +: 8] = dqS_r;
          ce_nxt   = 1'b1;
          oe_nxt   = 1'b1;
          cnt_nxt  = 8'h00;
          lane_nxt = lane_r + 2'h1;
          if (lane_r == 2'h3) rs_nxt = R_ACK;
        end
      end
      R_WE: begin
        if (cnt_r == 8'(ROM_WE_CYC - 1)) begin
          we_nxt = 1'b1;
          rs_nxt = R_ACK;
        end
      end
      R_ACK: begin
        // Chip enable rises a cycle after the write strobe, so the part latches on the strobe alone.
        ce_nxt   = 1'b1;
        dqOe_nxt = 1'b0;
        rs_nxt   = R_IDLE;
      end
      default: rs_nxt = R_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rs_r    <= R_IDLE;
      lane_r  <= 2'h0;
      be_r    <= 4'h0;
      cnt_r   <= 8'h00;
      romRd_r <= 32'h0000_0000;
      a_r     <= '0;
      dqOut_r <= 8'h00;
      dqM_r   <= 8'h00;
      dqS_r   <= 8'h00;
      ce_r    <= 1'b1;
      oe_r    <= 1'b1;
      we_r    <= 1'b1;
      dqOe_r  <= 1'b0;
    end else begin
      rs_r    <= rs_nxt;
      lane_r  <= lane_nxt;
      be_r    <= be_nxt;
      cnt_r   <= cnt_nxt;
      romRd_r <= romRd_nxt;
      a_r     <= a_nxt;
      dqOut_r <= dqOut_nxt;
      dqM_r   <= romPinDqIn;
      dqS_r   <= dqM_r;
      ce_r    <= ce_nxt;
      oe_r    <= oe_nxt;
      we_r    <= we_nxt;
      dqOe_r  <= dqOe_nxt;
    end
  end
endmodule : eor_top

// >>> testbench/eor_props.sv
// Port checker for the nonvolatile store and option ROM unit.
`timescale 1ns/1ps
module eor_props #(
  parameter int NV_DWORDS = eor_pkg::NV_DWORDS_DEF
) (
  input wire logic                         sys_clk,
  input wire logic                         rst_n,
  input wire logic                         regWrEn,
  input wire logic                         regRdEn,
  input wire logic [7:0]                   regAddr,
  input wire logic [31:0]                  regWrData,
  input wire logic [31:0]                  regRdData,
  input wire logic                         romReq,
  input wire logic                         romWr,
  input wire logic                         romHit,
  input wire logic                         romAck,
  input wire logic                         romPinWe_n,
  input wire logic                         romStrapPresent,
  input wire logic                         flashStrapPresent,
  input wire logic                         cfgLoadValid,
  input wire logic [$clog2(NV_DWORDS)-1:0] cfgLoadIndex,
  input wire logic                         cfgLoadDone
);
  import eor_pkg::*;
  localparam int RD_MAX = 4 * (ROM_ACC_CYC + 4) + 8;
  logic fwen_r;
  logic fwen_nxt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Mirrors the flash write enable bit as written by the host.
  always_comb begin
    fwen_nxt = fwen_r;
    if (regWrEn && regAddr == REG_NV_CTRL) fwen_nxt = regWrData[NV_FWEN_BIT];
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) fwen_r <= 1'b0;
    else fwen_r <= fwen_nxt;
  end
  chk_ack_one_cycle: assert property (romAck |=> !romAck)
    else $error("rom ack longer than one cycle");
  chk_ack_with_req: assert property (romAck |-> romReq)
    else $error("rom ack without request");
  chk_rd_answer: assert property (romReq && romHit && !romWr |-> ##[0:RD_MAX] romAck)
    else $error("rom read not answered");
  chk_write_gated: assert property ($fell(romPinWe_n) |-> fwen_r && flashStrapPresent)
    else $error("rom write strobe while writes disabled");
  chk_base_absent: assert property (regRdEn && regAddr == CFG_ROM_BASE && !romStrapPresent |=> regRdData == 32'h0)
    else $error("rom base readable without rom");
  chk_load_index: assert property (cfgLoadValid |-> cfgLoadIndex < NV_DWORDS - 1)
    else $error("sum dword streamed as load");
  chk_load_before_done: assert property (cfgLoadValid |-> !cfgLoadDone)
    else $error("load and done together");
  chk_done_pulse: assert property (cfgLoadDone |=> !cfgLoadDone)
    else $error("reload done longer than one cycle");
endmodule : eor_props
bind eor_top eor_props #(.NV_DWORDS(NV_DWORDS)) i_props (.*);

// >>> testbench/eor_nv_model.sv
// Serial EEPROM and byte-wide option ROM seen by the unit.
`timescale 1ns/1ps
module eor_nv_model #(
  parameter int AW = 12
) (
  input  wire logic          nvCs,
  input  wire logic          nvSk,
  input  wire logic          nvDi,
  output logic               nvDo,
  input  wire logic          eePresent,
  input  wire logic [AW-1:0] romPinAddr,
  input  wire logic [7:0]    romPinDqOut,
  input  wire logic          romPinCe_n,
  input  wire logic          romPinOe_n,
  input  wire logic          romPinWe_n,
  output logic      [7:0]    romPinDqIn
);
  logic [15:0] ee [0:63];
  logic [7:0]  rom [0:(1<<AW)-1];
  logic [8:0]  cmd;
  logic [15:0] sh;
  logic [7:0]  lastQ = 8'h00;
  logic        dq = 1'b1;
  logic        wpend = 1'b0;
  int          n = 0;
  initial for (int k = 0; k < (1 << AW); k++) rom[k] = 8'(k) ^ 8'h5A;
  // The line has a pull-up, so an absent or deselected part reads high.
  assign nvDo = (eePresent && nvCs) ? dq : 1'b1;
  always @(posedge nvCs) begin
    n = 0;
    dq = !wpend;
    if (wpend) dq <= #400 1'b1;
    wpend = 1'b0;
  end
  always @(posedge nvSk) if (nvCs) begin
    if (n < 9) cmd = {cmd[7:0], nvDi};
    else if (n < 25) sh = {sh[14:0], nvDi};
    if (cmd[7:6] == 2'b10 && n >= 9 && n <= 25) dq = (n == 9) ? 1'b0 : ee[cmd[5:0]][25-n];
    n++;
  end
  always @(negedge nvCs) if (n == 25 && cmd[7:6] == 2'b01) begin
    ee[cmd[5:0]] = sh;
    wpend = 1'b1;
  end
  assign romPinDqIn = (!romPinCe_n && !romPinOe_n) ? rom[romPinAddr] : ~lastQ;
  always @(posedge romPinOe_n) if (!romPinCe_n) lastQ = rom[romPinAddr];
  always @(posedge romPinWe_n) if (!romPinCe_n) rom[romPinAddr] = romPinDqOut;
endmodule : eor_nv_model

// >>> testbench/tb_top.sv
// Self-checking bench for the nonvolatile store and option ROM unit.
`timescale 1ns/1ps
module tb_top;
  import eor_pkg::*;
  logic        sys_clk = 0, rst_n = 0, regWrEn = 0, regRdEn = 0, romReq = 0, romWr = 0;
  logic        romStrapPresent = 1, flashStrapPresent = 1, eePresent = 1;
  logic [7:0]  regAddr = 0, romPinDqIn, romPinDqOut, b;
  logic [31:0] regWrData = 0, romAddr = 0, romWrData = 0, regRdData, romRdData, cfgLoadData, ldData;
  logic [3:0]  romBe = 0;
  logic [11:0] romPinAddr;
  logic        romHit, romAck, romPinDqOe, romPinCe_n, romPinOe_n, romPinWe_n, nvCs, nvSk, nvDi, nvDo;
  logic        cfgLoadValid, cfgLoadDone, nvStorePresent, nvChecksumError;
  logic [0:0]  cfgLoadIndex;
  logic [3:0]  beTab [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF};
  int          n_mismatch = 0, samples_checked = 0, nDone = 0;
  eor_top #(.WR_WAIT_CYC(200), .NV_DWORDS(2)) i_dut (.*);
  eor_nv_model #(.AW(12)) i_nv (.*);
  initial forever #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (cfgLoadValid) ldData <= cfgLoadData;
    if (cfgLoadDone) nDone <= nDone + 1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge sys_clk);
    {regWrEn, regAddr, regWrData} = {1'b1, a, d};
    @(negedge sys_clk);
    regWrEn = 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge sys_clk);
    {regRdEn, regAddr} = {1'b1, a};
    @(negedge sys_clk);
    regRdEn = 0;
    d = regRdData;
  endtask : rd
  task automatic wait_idle;
    logic [31:0] d;
    for (int i = 0; i < 40000; i++) begin
      rd(REG_NV_CTRL, d);
      if (d[NV_BUSY_BIT] === 1'b0) break;
    end
  endtask : wait_idle
  task automatic rom(input logic w, input logic [11:0] a, input logic [3:0] be, input logic [31:0] wd,
                     output logic [31:0] q);
    @(negedge sys_clk);
    {romReq, romWr, romAddr, romBe, romWrData} = {1'b1, w, 32'h0010_0000 + a, be, wd};
    do @(negedge sys_clk); while (romAck !== 1'b1);
    q = romRdData;
    @(negedge sys_clk);
    romReq = 0;
  endtask : rom
  function automatic logic [31:0] romExp(input logic [11:0] a, input logic [3:0] be, input logic m);
    for (int k = 0; k < 4; k++) romExp[8*k +: 8] = !be[k] ? 8'h00 : m ? 8'hFF : i_nv.rom[a + k];
  endfunction : romExp
  initial begin
    logic [31:0] d, q, dw0;
    logic [11:0] a;
    logic [3:0]  be;
    void'($urandom(38234));
    dw0 = $urandom;
    {i_nv.ee[0], i_nv.ee[1]} = dw0;
    {i_nv.ee[2], i_nv.ee[3]} = dw0 + 1;
    repeat (2) @(negedge sys_clk);
    rst_n = 1;
    rd(REG_NV_CTRL, d);
    check(32'(d[NV_BUSY_BIT]), 32'h1);
    wait_idle;
    rd(REG_NV_CTRL, d);
    check(32'(d[15:12]), 32'h7);
    check(32'({nvChecksumError, nvStorePresent}), 32'h3);
    check(ldData, dw0);
    wr(CFG_ROM_BASE, 32'hFFFF_FFFF);
    rd(CFG_ROM_BASE, d);
    check(d, 32'hFFFF_F001);
    wr(CFG_ROM_BASE, 32'h0010_0001);
    for (int i = 0; i < 8; i++) begin
      a = 12'($urandom) & 12'hFFC;
      be = beTab[$urandom % 7];
      rom(0, a, be, 0, q);
      check(q & romExp(a, be, 1), romExp(a, be, 0));
    end
    b = ~i_nv.rom[5];
    rom(1, 12'h005, 4'h2, {16'h0, b, 8'h0}, q);
    check(i_nv.rom[5], {24'h0, ~b});
    wr(REG_NV_CTRL, 32'h0000_8000);
    rom(1, 12'h005, 4'h2, {16'h0, b, 8'h0}, q);
    check(i_nv.rom[5], b);
    rom(1, 12'h004, 4'h3, 32'h0, q);
    check(i_nv.rom[4], 8'h04 ^ 8'h5A);
    wr(REG_NV_CTRL, 32'h0000_8501);
    wait_idle;
    rd(REG_NV_DATA, d);
    check(d, dw0 + 1);
    wr(REG_NV_DATA, dw0);
    wr(REG_NV_CTRL, 32'h0000_8601);
    wr(REG_NV_DATA, ~dw0);
    wr(REG_NV_CTRL, 32'h0000_8500);
    rd(REG_NV_CTRL, d);
    check(32'(d[NV_BUSY_BIT]), 32'h1);
    wait_idle;
    check({i_nv.ee[2], i_nv.ee[3]}, dw0);
    rd(REG_NV_DATA, d);
    check(d, dw0);
    rst_n = 0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1;
    wait_idle;
    rd(REG_NV_CTRL, d);
    check(32'(d[15:12]), 32'h5);
    check(32'({nvChecksumError, nvStorePresent}), 32'h1);
    check(ldData, dw0);
    {rst_n, eePresent, romStrapPresent, flashStrapPresent} = 4'h0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1;
    wait_idle;
    rd(REG_NV_CTRL, d);
    check(32'(d[15:12]), 32'h0);
    wr(CFG_ROM_BASE, 32'hFFFF_FFFF);
    rd(CFG_ROM_BASE, d);
    check(d, 32'h0);
    check(32'(nDone), 32'h3);
    test_done;
  end
  initial begin
    repeat (105000) @(posedge sys_clk);
    n_mismatch++;
    test_done;
  end
endmodule : tb_top
